// ===== rtl/pab_pkg.sv
// Constants and state type for the coding-sublayer and negotiation register bank
package pab_pkg;

  // ----------------------------------------
  // Management device addresses
  // ----------------------------------------
  localparam logic [4:0] DEV_PCS = 5'h03;
  localparam logic [4:0] DEV_AN = 5'h07;

  // ----------------------------------------
  // Coding-sublayer register offsets
  // ----------------------------------------
  localparam logic [15:0] REG_CODING_STATUS_TWO = 16'h0008;
  localparam logic [15:0] REG_PCS_CTRL = 16'h08E6;
  localparam logic [15:0] REG_PCS_STAT = 16'h08E7;

  // ----------------------------------------
  // Negotiation register offsets
  // ----------------------------------------
  localparam logic [15:0] REG_DEVS_ONE = 16'h0005;
  localparam logic [15:0] REG_DEVS_TWO = 16'h0006;
  localparam logic [15:0] REG_AN_CTRL = 16'h0200;
  localparam logic [15:0] REG_AN_STAT = 16'h0201;
  localparam logic [15:0] REG_ADV_L = 16'h0202;
  localparam logic [15:0] REG_ADV_M = 16'h0203;
  localparam logic [15:0] REG_ADV_H = 16'h0204;
  localparam logic [15:0] REG_BP_L = 16'h0205;
  localparam logic [15:0] REG_BP_M = 16'h0206;
  localparam logic [15:0] REG_BP_H = 16'h0207;
  localparam logic [15:0] REG_NP_L = 16'h0208;
  localparam logic [15:0] REG_NP_M = 16'h0209;
  localparam logic [15:0] REG_NP_H = 16'h020A;
  localparam logic [15:0] REG_LNP_L = 16'h020B;
  localparam logic [15:0] REG_LNP_M = 16'h020C;
  localparam logic [15:0] REG_LNP_H = 16'h020D;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] RST_CODING_STATUS_TWO = 16'h8000;
  localparam logic [15:0] RST_DEVS_ONE = 16'h008B;
  localparam logic [15:0] RST_DEVS_TWO = 16'hC000;
  localparam logic [15:0] RST_AN_CTRL = 16'h1000;
  localparam logic [15:0] RST_ADV_L = 16'h0001;
  localparam logic [15:0] RST_ADV_M = 16'h4000;
  localparam logic [15:0] RST_NP_L = 16'h2001;
  localparam logic [15:0] RST_ZERO = 16'h0000;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int AN_CTRL_RESET_BIT = 15;
  localparam int AN_CTRL_RESTART_BIT = 9;
  localparam int LVL_ABLE_BIT = 13;
  localparam int LVL_REQ_BIT = 12;
  localparam logic [15:0] BP_H_MASK = 16'h7800;

  // ----------------------------------------
  // Indirect access through the short-frame register space
  // ----------------------------------------
  localparam logic [4:0] C22_ACC_CTRL = 5'h0D;
  localparam logic [4:0] C22_ACC_DATA = 5'h0E;
  localparam logic [1:0] FN_ADDR = 2'h0;
  localparam logic [1:0] FN_DATA = 2'h1;
  localparam logic [1:0] FN_INC_RW = 2'h2;
  localparam logic [1:0] FN_INC_WR = 2'h3;

  typedef struct packed {
    logic [15:0] pcs_ctrl;
    logic [15:0] an_ctrl;
    logic [15:0] adv_l;
    logic [15:0] adv_m;
    logic [15:0] adv_h;
    logic [15:0] np_l;
    logic [15:0] np_m;
    logic [15:0] np_h;
    logic [47:0] np_out;
    logic np_commit;
    logic an_restart;
    logic lvl_hi;
    logic [15:0] bp_mid;
    logic [15:0] bp_high;
    logic [15:0] lnp_mid;
    logic [15:0] lnp_high;
    logic [15:0] acc_ctrl;
    logic [15:0] acc_addr;
    logic [15:0] rdata;
    logic rvalid;
  } pab_state_type;

endpackage

// ===== rtl/pab_register_bank.sv
// Management register bank for the coding sublayer and single-pair negotiation
//
// Function
// [R1] Coding-sublayer registers answer under device 0x03 and negotiation registers under device 0x07.
// [R2] The first devices-present word of the negotiation device reads 0x008B.
// [R3] The second devices-present word of the negotiation device reads 0xC000.
// [R4] Reading the partner base-page low word captures its middle and high words in the same access.
// [R5] Reads of the partner base-page middle and high words return the capture of the last low-word read.
// [R6] Reading the partner next-page low word captures its middle and high words for later reads.
// [R7] Power-up and every negotiation reset restore the three next-page transmit words, low word 0x2001.
// [R8] The host writes the middle and high next-page transmit words before the low one.
// [R9] Bit 14 of the partner base-page high word is a read-only energy-saving flag, zero after reset.
// [R10] Bit 13 of the partner base-page high word is a read-only high-level ability flag, zero after reset.
// [R11] Bit 12 of the partner base-page high word is a read-only high-level request flag, zero after reset.
// [R12] Local ability, partner ability, partner request and local request together choose the high or low transmit level.
// [R13] Bit 11 of the partner base-page high word is a read-only short-reach half-duplex flag, zero after reset.
// [R14] Bit 15 and bits 10 to 0 of the partner base-page high word read as zero.
// [R15] The device registers are also reached indirectly through an access-control and an access register.
// [R16] A write of the next-page low word commits all three words as one 48-bit page.
`timescale 1ns/1ps

module pab_register_bank
  import pab_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Management requests
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_c22,
  input wire logic [4:0] req_dev,
  input wire logic [15:0] req_reg,
  input wire logic [15:0] req_wdata,
  output logic resp_valid,
  output logic [15:0] resp_rdata,
  // Negotiation engine side
  input wire logic an_reset,
  input wire logic [47:0] lp_base_page,
  input wire logic [47:0] lp_next_page,
  input wire logic [15:0] negotiation_status,
  input wire logic [15:0] pcs_status,
  // Configuration outputs
  output logic [15:0] pcs_control,
  output logic [15:0] negotiation_control,
  output logic [47:0] local_advert,
  output logic [47:0] next_page_tx,
  output logic next_page_commit,
  output logic an_restart,
  output logic tx_level_high
);
  import pab_pkg::*;

  pab_state_type s_q;
  pab_state_type s_d;

  logic mmd_acc;
  logic mmd_wr;
  logic mmd_rd;
  logic [4:0] mmd_dev;
  logic [15:0] mmd_reg;
  logic [15:0] mmd_val;
  logic neg_reset;
  logic [1:0] acc_fn;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic hit(input logic [4:0] dev, input logic [15:0] rg,
                               input logic [4:0] want_dev, input logic [15:0] want_rg);
    hit = (dev == want_dev) && (rg == want_rg);
  endfunction

  // Words of a 48-bit page; the low word goes first on the wire
  function automatic logic [15:0] page_low(input logic [47:0] page);
    page_low = page[15:0];
  endfunction

  function automatic logic [15:0] page_mid(input logic [47:0] page);
    page_mid = page[31:16];
  endfunction

  function automatic logic [15:0] page_high(input logic [47:0] page);
    page_high = page[47:32];
  endfunction

  function automatic logic [47:0] make_page(input logic [15:0] high, input logic [15:0] mid,
                                            input logic [15:0] low);
    make_page = {high, mid, low};
  endfunction

  // Fields of the indirect access-control word
  function automatic logic [1:0] acc_mode(input logic [15:0] ctrl);
    acc_mode = ctrl[15:14];
  endfunction

  function automatic logic [4:0] acc_device(input logic [15:0] ctrl);
    acc_device = ctrl[4:0];
  endfunction

  // Short frames carry only a 5-bit register number
  function automatic logic [4:0] c22_number(input logic [15:0] rg);
    c22_number = rg[4:0];
  endfunction

  // Both ends must be able and at least one must ask
  function automatic logic pick_high_level(input logic [15:0] local_word, input logic [15:0] partner_word);
    pick_high_level = local_word[LVL_ABLE_BIT] && partner_word[LVL_ABLE_BIT]
                      && (local_word[LVL_REQ_BIT] || partner_word[LVL_REQ_BIT]);
  endfunction

  assign acc_fn = acc_mode(s_q.acc_ctrl);

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.np_commit = 1'b0;
    s_d.an_restart = 1'b0;
    s_d.rvalid = req_valid;
    mmd_acc = 1'b0;
    mmd_wr = 1'b0;
    mmd_rd = 1'b0;
    mmd_dev = req_dev;
    mmd_reg = req_reg;
    mmd_val = RST_ZERO;
    neg_reset = an_reset;

    // Route the request: direct long-frame access or indirect via the short-frame pair
    if (req_valid && !req_c22)
    begin
      mmd_acc = 1'b1;
    end
    else if (req_valid && req_c22)
    begin
      s_d.rdata = RST_ZERO;
      case (c22_number(req_reg))
        C22_ACC_CTRL:
        begin
          if (req_write)
          begin
            s_d.acc_ctrl = req_wdata; // R15
          end
          else
          begin
            s_d.rdata = s_q.acc_ctrl;
          end
        end
        C22_ACC_DATA:
        begin
          if (acc_fn == FN_ADDR)
          begin
            if (req_write)
            begin
              s_d.acc_addr = req_wdata; // R15
            end
            else
            begin
              s_d.rdata = s_q.acc_addr;
            end
          end
          else
          begin
            mmd_acc = 1'b1; // R15
            mmd_dev = acc_device(s_q.acc_ctrl);
            mmd_reg = s_q.acc_addr;
            // Post-increment lets a host stream through a page of words
            if ((acc_fn == FN_INC_RW) || ((acc_fn == FN_INC_WR) && req_write))
            begin
              s_d.acc_addr = s_q.acc_addr + 16'h0001;
            end
          end
        end
        default:
        begin
          s_d.rdata = RST_ZERO;
        end
      endcase
    end

    mmd_wr = mmd_acc && req_write;
    mmd_rd = mmd_acc && !req_write;

    // Read decode; unmapped addresses read as zero
    if (mmd_dev == DEV_PCS) // R1
    begin
      case (mmd_reg)
        REG_CODING_STATUS_TWO: mmd_val = RST_CODING_STATUS_TWO;
        REG_PCS_CTRL: mmd_val = s_q.pcs_ctrl;
        REG_PCS_STAT: mmd_val = pcs_status;
        default: mmd_val = RST_ZERO;
      endcase
    end
    else if (mmd_dev == DEV_AN) // R1
    begin
      case (mmd_reg)
        REG_DEVS_ONE: mmd_val = RST_DEVS_ONE; // R2
        REG_DEVS_TWO: mmd_val = RST_DEVS_TWO; // R3
        REG_AN_CTRL: mmd_val = s_q.an_ctrl;
        REG_AN_STAT: mmd_val = negotiation_status;
        REG_ADV_L: mmd_val = s_q.adv_l;
        REG_ADV_M: mmd_val = s_q.adv_m;
        REG_ADV_H: mmd_val = s_q.adv_h;
        REG_BP_L: mmd_val = page_low(lp_base_page);
        REG_BP_M: mmd_val = s_q.bp_mid; // R5
        REG_BP_H: mmd_val = s_q.bp_high; // R5
        REG_NP_L: mmd_val = s_q.np_l;
        REG_NP_M: mmd_val = s_q.np_m;
        REG_NP_H: mmd_val = s_q.np_h;
        REG_LNP_L: mmd_val = page_low(lp_next_page);
        REG_LNP_M: mmd_val = s_q.lnp_mid; // R6
        REG_LNP_H: mmd_val = s_q.lnp_high; // R6
        default: mmd_val = RST_ZERO;
      endcase
    end
    else
    begin
      mmd_val = RST_ZERO;
    end

    if (mmd_rd)
    begin
      s_d.rdata = mmd_val;
    end

    // Low-word reads freeze the upper words so a multi-read sees one page
    if (mmd_rd && hit(mmd_dev, mmd_reg, DEV_AN, REG_BP_L))
    begin
      s_d.bp_mid = page_mid(lp_base_page); // R4
      s_d.bp_high = page_high(lp_base_page) & BP_H_MASK; // R4 R9 R10 R11 R13 R14
    end
    if (mmd_rd && hit(mmd_dev, mmd_reg, DEV_AN, REG_LNP_L))
    begin
      s_d.lnp_mid = page_mid(lp_next_page); // R6
      s_d.lnp_high = page_high(lp_next_page); // R6
    end

    // Writes; read-only addresses ignore them
    if (mmd_wr)
    begin
      if (hit(mmd_dev, mmd_reg, DEV_PCS, REG_PCS_CTRL))
      begin
        s_d.pcs_ctrl = req_wdata;
      end
      if (hit(mmd_dev, mmd_reg, DEV_AN, REG_AN_CTRL))
      begin
        // Reset and restart are self-clearing commands, never stored
        s_d.an_ctrl = req_wdata;
        s_d.an_ctrl[AN_CTRL_RESET_BIT] = 1'b0;
        s_d.an_ctrl[AN_CTRL_RESTART_BIT] = 1'b0;
        s_d.an_restart = req_wdata[AN_CTRL_RESTART_BIT];
        if (req_wdata[AN_CTRL_RESET_BIT])
        begin
          neg_reset = 1'b1;
        end
      end
      if (hit(mmd_dev, mmd_reg, DEV_AN, REG_ADV_L))
      begin
        s_d.adv_l = req_wdata;
      end
      if (hit(mmd_dev, mmd_reg, DEV_AN, REG_ADV_M))
      begin
        s_d.adv_m = req_wdata;
      end
      if (hit(mmd_dev, mmd_reg, DEV_AN, REG_ADV_H))
      begin
        s_d.adv_h = req_wdata;
      end
      // Upper words only stage; the host fills them first
      if (hit(mmd_dev, mmd_reg, DEV_AN, REG_NP_M))
      begin
        s_d.np_m = req_wdata; // R8
      end
      if (hit(mmd_dev, mmd_reg, DEV_AN, REG_NP_H))
      begin
        s_d.np_h = req_wdata; // R8
      end
      if (hit(mmd_dev, mmd_reg, DEV_AN, REG_NP_L))
      begin
        s_d.np_l = req_wdata;
        s_d.np_out = make_page(s_q.np_h, s_q.np_m, req_wdata); // R16
        s_d.np_commit = 1'b1; // R16
      end
    end

    // Negotiation reset overrides any same-cycle page write
    if (neg_reset)
    begin
      s_d.np_l = RST_NP_L; // R7
      s_d.np_m = RST_ZERO; // R7
      s_d.np_h = RST_ZERO; // R7
      s_d.np_out = make_page(RST_ZERO, RST_ZERO, RST_NP_L); // R7
      s_d.np_commit = 1'b0;
    end

    s_d.lvl_hi = pick_high_level(s_q.adv_h, page_high(lp_base_page)); // R12
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q.pcs_ctrl <= RST_ZERO;
      s_q.an_ctrl <= RST_AN_CTRL;
      s_q.adv_l <= RST_ADV_L;
      s_q.adv_m <= RST_ADV_M;
      s_q.adv_h <= RST_ZERO;
      s_q.np_l <= RST_NP_L; // R7
      s_q.np_m <= RST_ZERO;
      s_q.np_h <= RST_ZERO;
      s_q.np_out <= {RST_ZERO, RST_ZERO, RST_NP_L};
      s_q.np_commit <= 1'b0;
      s_q.an_restart <= 1'b0;
      s_q.lvl_hi <= 1'b0;
      s_q.bp_mid <= RST_ZERO;
      s_q.bp_high <= RST_ZERO; // R9 R10 R11 R13
      s_q.lnp_mid <= RST_ZERO;
      s_q.lnp_high <= RST_ZERO;
      s_q.acc_ctrl <= RST_ZERO;
      s_q.acc_addr <= RST_ZERO;
      s_q.rdata <= RST_ZERO;
      s_q.rvalid <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign resp_valid = s_q.rvalid;
  assign resp_rdata = s_q.rdata;
  assign pcs_control = s_q.pcs_ctrl;
  assign negotiation_control = s_q.an_ctrl;
  assign local_advert = {s_q.adv_h, s_q.adv_m, s_q.adv_l};
  assign next_page_tx = s_q.np_out;
  assign next_page_commit = s_q.np_commit;
  assign an_restart = s_q.an_restart;
  assign tx_level_high = s_q.lvl_hi;

endmodule

// ===== verif/pab_engine_model.sv
// Negotiation engine stand-in driving live partner pages and status words
`timescale 1ns/1ps
module pab_engine_model
  import pab_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Level flags forced by the bench
  input wire logic [1:0] lvl,
  // Live words toward the bank
  output logic [47:0] lp_base_page,
  output logic [47:0] lp_next_page,
  output logic [15:0] negotiation_status,
  output logic [15:0] pcs_status
);
  logic [15:0] cnt_q;
  // Words move every cycle, so a missing capture shows as a mismatch
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
      cnt_q <= 16'h0000;
    else
      cnt_q <= cnt_q + 16'h1357;
  assign lp_base_page = {~cnt_q[15:14], lvl, cnt_q[11:0], cnt_q ^ 16'hA5A5, ~cnt_q};
  assign lp_next_page = {cnt_q ^ 16'h0F0F, ~cnt_q ^ 16'h3C3C, cnt_q};
  assign negotiation_status = cnt_q ^ 16'h00FF;
  assign pcs_status = ~cnt_q;
endmodule

// ===== verif/pab_register_bank_properties.sv
// Checker for the register bank management port
`timescale 1ns/1ps
module pab_register_bank_properties
  import pab_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_c22,
  input wire logic [4:0] req_dev,
  input wire logic [15:0] req_reg,
  input wire logic [15:0] req_wdata,
  input wire logic resp_valid,
  input wire logic [15:0] resp_rdata,
  input wire logic an_reset,
  input wire logic [47:0] lp_base_page,
  input wire logic [47:0] lp_next_page,
  input wire logic [15:0] pcs_status,
  input wire logic [47:0] local_advert,
  input wire logic [47:0] next_page_tx,
  input wire logic next_page_commit,
  input wire logic an_restart,
  input wire logic tx_level_high
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic rd7;
  logic wr7;
  assign rd7 = req_valid && !req_write && !req_c22 && req_dev == DEV_AN;
  assign wr7 = req_valid && req_write && !req_c22 && req_dev == DEV_AN;
  resp_next_a: assert property (req_valid |=> resp_valid) else $error("no answer");
  resp_idle_a: assert property (!req_valid |=> !resp_valid) else $error("stray answer");
  devs_one_a: assert property (rd7 && req_reg == REG_DEVS_ONE |=> resp_rdata == 16'h008B)
    else $error("devices word one");
  devs_two_a: assert property (rd7 && req_reg == REG_DEVS_TWO |=> resp_rdata == 16'hC000)
    else $error("devices word two");
  base_low_a: assert property (rd7 && req_reg == REG_BP_L |=> resp_rdata == $past(lp_base_page[15:0]))
    else $error("base low word");
  base_high_a: assert property (rd7 && req_reg == REG_BP_H |=> (resp_rdata & 16'h87FF) == 16'h0000)
    else $error("base high reserved bits");
  next_low_a: assert property (rd7 && req_reg == REG_LNP_L |=> resp_rdata == $past(lp_next_page[15:0]))
    else $error("next low word");
  pcs_dev_a: assert property (req_valid && !req_write && !req_c22 && req_dev == DEV_PCS && req_reg == REG_PCS_STAT
    |=> resp_rdata == $past(pcs_status)) else $error("coding status");
  page_commit_a: assert property (wr7 && req_reg == REG_NP_L && !an_reset
    |=> next_page_commit && next_page_tx[15:0] == $past(req_wdata)) else $error("page commit");
  page_reset_a: assert property (an_reset |=> next_page_tx == 48'h0000_0000_2001 && !next_page_commit)
    else $error("page reset");
  level_pick_a: assert property (tx_level_high == $past(local_advert[45] & lp_base_page[45]
    & (local_advert[44] | lp_base_page[44]))) else $error("level choice");
  restart_pulse_a: assert property (wr7 && req_reg == REG_AN_CTRL && req_wdata[9] |=> an_restart ##1 !an_restart)
    else $error("restart pulse");
endmodule
bind pab_register_bank pab_register_bank_properties u_props (.clock, .rst_b, .req_valid, .req_write, .req_c22,
  .req_dev, .req_reg, .req_wdata, .resp_valid, .resp_rdata, .an_reset, .lp_base_page, .lp_next_page,
  .pcs_status, .local_advert, .next_page_tx, .next_page_commit, .an_restart, .tx_level_high);

// ===== verif/pab_register_bank_tb.sv
// Self-checking bench for the coding-sublayer and negotiation register bank
`timescale 1ns/1ps
module pab_register_bank_tb;
  import pab_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic req_c22 = 1'b0;
  logic [4:0] req_dev = 5'h00;
  logic [15:0] req_reg = 16'h0000;
  logic [15:0] req_wdata = 16'h0000;
  logic an_reset = 1'b0;
  logic [1:0] lvl = 2'h0;
  logic resp_valid, next_page_commit, an_restart, tx_level_high;
  logic [15:0] resp_rdata, negotiation_status, pcs_status, pcs_control, negotiation_control, rd, live_s, live_a;
  logic [47:0] lp_base_page, lp_next_page, local_advert, next_page_tx, live_b, live_n;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  always #50 clock = ~clock;
  pab_register_bank uut (.clock, .rst_b, .req_valid, .req_write, .req_c22, .req_dev, .req_reg, .req_wdata,
    .resp_valid, .resp_rdata, .an_reset, .lp_base_page, .lp_next_page, .negotiation_status, .pcs_status,
    .pcs_control, .negotiation_control, .local_advert, .next_page_tx, .next_page_commit, .an_restart,
    .tx_level_high);
  pab_engine_model engine (.clock, .rst_b, .lvl, .lp_base_page, .lp_next_page, .negotiation_status, .pcs_status);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic finish_test();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One request, held across its taking edge; live words saved as sampled there
  task automatic req(input logic w, input logic c22, input logic [4:0] dev, input logic [15:0] rg,
    input logic [15:0] wd);
    @(negedge clock);
    req_valid = 1'b1;
    req_write = w;
    req_c22 = c22;
    req_dev = dev;
    req_reg = rg;
    req_wdata = wd;
    live_b = lp_base_page;
    live_n = lp_next_page;
    live_s = pcs_status;
    live_a = negotiation_status;
    @(negedge clock);
    req_valid = 1'b0;
    check("resp_valid", 1'b1, resp_valid);
    rd = resp_rdata;
  endtask
  task automatic do_reset();
    @(negedge clock);
    rst_b = 1'b0;
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_values();
    logic [15:0] regs [13] = '{REG_DEVS_ONE, REG_DEVS_TWO, REG_AN_CTRL, REG_ADV_L, REG_ADV_M, REG_ADV_H,
      REG_BP_M, REG_BP_H, REG_NP_L, REG_NP_M, REG_NP_H, REG_LNP_M, REG_LNP_H};
    logic [15:0] vals [13] = '{16'h008B, 16'hC000, 16'h1000, 16'h0001, 16'h4000, 16'h0000,
      16'h0000, 16'h0000, 16'h2001, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    check("negotiation_control", 16'h1000, negotiation_control);
    check("pcs_control", 16'h0000, pcs_control);
    check("local_advert", 48'h0000_4000_0001, local_advert);
    check("next_page_tx", 48'h0000_0000_2001, next_page_tx);
    for (int i = 0; i < 13; i++)
    begin
      req(1'b0, 1'b0, DEV_AN, regs[i], 16'h0000);
      check("reset read", vals[i], rd);
    end
    req(1'b1, 1'b0, DEV_AN, REG_DEVS_ONE, 16'hFFFF);
    req(1'b0, 1'b0, DEV_AN, REG_DEVS_ONE, 16'h0000);
    check("read-only devices word", 16'h008B, rd);
    req(1'b0, 1'b0, DEV_PCS, REG_CODING_STATUS_TWO, 16'h0000);
    check("coding status two", 16'h8000, rd);
    req(1'b0, 1'b0, DEV_AN, REG_CODING_STATUS_TWO, 16'h0000);
    check("wrong device", 16'h0000, rd);
    req(1'b0, 1'b0, DEV_PCS, REG_PCS_STAT, 16'h0000);
    check("coding status", live_s, rd);
    req(1'b0, 1'b0, DEV_AN, REG_AN_STAT, 16'h0000);
    check("negotiation status", live_a, rd);
    req(1'b1, 1'b0, DEV_PCS, REG_PCS_CTRL, 16'h5A5A);
    req(1'b1, 1'b0, DEV_AN, REG_PCS_CTRL, 16'hFFFF);
    check("coding control", 16'h5A5A, pcs_control);
    req(1'b0, 1'b0, DEV_PCS, REG_PCS_CTRL, 16'h0000);
    check("coding control read", 16'h5A5A, rd);
  endtask
  task automatic t_snapshots();
    logic [15:0] low;
    logic [47:0] snap;
    for (int k = 0; k < 2; k++)
    begin
      low = k ? REG_LNP_L : REG_BP_L;
      req(1'b0, 1'b0, DEV_AN, low, 16'h0000);
      snap = k ? live_n : live_b;
      check("low word", snap[15:0], rd);
      repeat (3) @(negedge clock);
      req(1'b0, 1'b0, DEV_AN, low + 16'h0001, 16'h0000);
      check("mid snapshot", snap[31:16], rd);
      req(1'b0, 1'b0, DEV_AN, low + 16'h0002, 16'h0000);
      check("high snapshot", snap[47:32] & (k ? 16'hFFFF : BP_H_MASK), rd);
    end
  endtask
  task automatic t_next_page();
    req(1'b1, 1'b0, DEV_AN, REG_NP_M, 16'h1111);
    check("no early commit", 1'b0, next_page_commit);
    req(1'b1, 1'b0, DEV_AN, REG_NP_H, 16'h2222);
    check("page held", 48'h0000_0000_2001, next_page_tx);
    req(1'b1, 1'b0, DEV_AN, REG_NP_L, 16'h3333);
    check("commit pulse", 1'b1, next_page_commit);
    check("committed page", 48'h2222_1111_3333, next_page_tx);
    @(negedge clock);
    an_reset = 1'b1;
    @(negedge clock);
    an_reset = 1'b0;
    check("page after reset", 48'h0000_0000_2001, next_page_tx);
    an_reset = 1'b1;
    req(1'b1, 1'b0, DEV_AN, REG_NP_L, 16'h4444);
    an_reset = 1'b0;
    check("no commit on reset", 1'b0, next_page_commit);
    check("reset beats write", 48'h0000_0000_2001, next_page_tx);
    req(1'b0, 1'b0, DEV_AN, REG_NP_H, 16'h0000);
    check("high after reset", 16'h0000, rd);
    req(1'b1, 1'b0, DEV_AN, REG_NP_M, 16'h5555);
    req(1'b1, 1'b0, DEV_AN, REG_AN_CTRL, 16'h8000);
    req(1'b0, 1'b0, DEV_AN, REG_NP_M, 16'h0000);
    check("mid after soft reset", 16'h0000, rd);
    req(1'b1, 1'b0, DEV_AN, REG_AN_CTRL, 16'h0200);
    check("restart pulse", 1'b1, an_restart);
    check("control bits clear", 16'h0000, negotiation_control);
  endtask
  task automatic t_level();
    for (int i = 0; i < 16; i++)
    begin
      lvl = i[1:0];
      req(1'b1, 1'b0, DEV_AN, REG_ADV_H, {2'b00, i[3:2], 12'h000});
      @(negedge clock);
      check("tx level", i[3] & i[1] & (i[2] | i[0]), tx_level_high);
      check("local high", {2'b00, i[3:2], 12'h000}, local_advert[47:32]);
    end
  endtask
  task automatic t_indirect();
    req(1'b1, 1'b1, 5'h00, 16'h000D, 16'h0007);
    req(1'b1, 1'b1, 5'h00, 16'h000E, REG_ADV_L);
    req(1'b1, 1'b1, 5'h00, 16'h000D, 16'h8007);
    req(1'b1, 1'b1, 5'h00, 16'h000E, 16'hBEEF);
    req(1'b1, 1'b1, 5'h00, 16'h000E, 16'h0123);
    check("indirect writes", 32'h0123_BEEF, local_advert[31:0]);
    req(1'b0, 1'b1, 5'h00, 16'h000D, 16'h0000);
    check("indirect control", 16'h8007, rd);
    req(1'b1, 1'b1, 5'h00, 16'h000D, 16'h0007);
    req(1'b0, 1'b1, 5'h00, 16'h000E, 16'h0000);
    check("post-increment address", REG_ADV_H, rd);
    req(1'b1, 1'b1, 5'h00, 16'h000E, REG_DEVS_ONE);
    req(1'b1, 1'b1, 5'h00, 16'h000D, 16'h4007);
    req(1'b0, 1'b1, 5'h00, 16'h000E, 16'h0000);
    check("indirect read plain", 16'h008B, rd);
    req(1'b1, 1'b1, 5'h00, 16'h000D, 16'hC007);
    req(1'b0, 1'b1, 5'h00, 16'h000E, 16'h0000);
    check("indirect read write-inc", 16'h008B, rd);
    req(1'b1, 1'b1, 5'h00, 16'h000D, 16'h0007);
    req(1'b0, 1'b1, 5'h00, 16'h000E, 16'h0000);
    check("no increment on reads", REG_DEVS_ONE, rd);
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      finish_test();
    end
  end
  initial
  begin
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    t_reset_values();
    t_snapshots();
    t_next_page();
    t_level();
    t_indirect();
    do_reset();
    t_reset_values();
    finish_test();
  end
endmodule
